// >>> nvl_i2c_host.sv
// i2c host model standing in for the optional microcontroller
`timescale 1ns/1ps
module nvl_i2c_host
	import nvl_pkg::*;
(
	input wire logic core_clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	// quarter bit time in core cycles; keeps both scl halves well above the sync latency
	int q = 6;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// release data first so a repeated start never looks like a stop
	task automatic start_cond();
		sda_low = 1'b0;
		tick(q);
		scl = 1'b1;
		tick(q);
		sda_low = 1'b1;
		tick(q);
		scl = 1'b0;
		tick(q);
	endtask
	task automatic stop_cond();
		sda_low = 1'b1;
		tick(q);
		scl = 1'b1;
		tick(q);
		sda_low = 1'b0;
		tick(2 * q);
	endtask
	// data changes mid-low and is sampled mid-high, never near an scl edge
	task automatic xfer_bit(input logic b, output logic r);
		sda_low = ~b;
		tick(q);
		scl = 1'b1;
		tick(q);
		r = sda_in;
		tick(q);
		scl = 1'b0;
		tick(q);
	endtask
	task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], b);
			r[i] = b;
		end
		xfer_bit(last, b);
		ack = ~b;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start_cond();
		xfer_byte({I2C_ADDR, 1'b0}, 1'b1, r, a0);
		xfer_byte(ptr, 1'b1, r, a1);
		xfer_byte(d, 1'b1, r, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
	// a single-byte read ends with a not-acknowledge from the host
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		start_cond();
		xfer_byte({I2C_ADDR, 1'b0}, 1'b1, r, a0);
		xfer_byte(ptr, 1'b1, r, a1);
		start_cond();
		xfer_byte({I2C_ADDR, 1'b1}, 1'b1, r, a2);
		xfer_byte(8'hFF, 1'b1, d, a3);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule // nvl_i2c_host

// >>> nvl_loader.sv
// start-up loader, configuration registers and i2c target
`timescale 1ns/1ps
module nvl_loader (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic reset_pin,
	input wire logic port_attached,
	input wire logic [31:0] prog_key,
	input wire logic prog_we,
	input wire logic [3:0] prog_idx,
	input wire logic [7:0] prog_data,
	output logic prog_refused,
	output logic cfg_ready,
	output logic typec_reset,
	output logic [2:0] alert_mask,
	output logic cable_supply_on,
	output logic cable_supply_drain_on,
	output logic [3:0] cable_supply_ilim,
	output logic cable_supply_mon_on,
	output logic cable_supply_low_trip_select,
	output logic [3:0] bus_low_limit_shift,
	output logic [3:0] bus_drain_time_coefficient,
	output logic bus_window_check_off,
	output logic supply_high_trip_off,
	output logic [1:0] bus_safe_zero_select,
	output logic supply_low_trip_off,
	output logic standby_off,
	output logic bus_drain_path_off
);
	import nvl_pkg::*;

	typedef struct packed {
		nvl_ld_t ld;
		logic [3:0] ldi;
		logic [NWORDS-1:0][7:0] regs;
		nvl_i2c_t st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic first;
		logic rw;
		logic nack;
		logic scl_q;
		logic sda_q;
		logic sda_o;
		logic sda_oe;
		logic ready;
		logic typec_rst;
		logic prog_refused;
		logic [2:0] amask;
		logic sup_on;
		logic drain_on;
		logic [3:0] ilim;
		logic mon_en;
		logic low_trip;
		logic [3:0] low_shift;
		logic [3:0] dtime;
		logic win_off;
		logic hi_off;
		logic [1:0] safe0;
		logic lo_off;
		logic stby_off;
		logic bdrain_off;
	} nvl_top_st_t;

	nvl_top_st_t s_r, s_nxt;
	logic scl_s, sda_s, rst_pin_s;
	logic [7:0] nvm_word;
	logic nvm_prog_ok;
	logic rise, fall, start, stop, wr_en;
	logic [3:0] wi;
	logic [7:0] limit_view;

	////////////////////////////////////////////////////////////////////////////////
	nvl_sync #(
		.W(3),
		.RST_VAL(SYNC_IDLE)
	) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.pin_in({reset_pin, sda_i, scl_i}),
		.pin_q({rst_pin_s, sda_s, scl_s})
	);

	nvl_nvm u_nvm (
		.core_clk(core_clk),
		.srst(srst),
		.prog_key(prog_key),
		.prog_we(prog_we),
		.prog_idx(prog_idx),
		.prog_data(prog_data),
		.rd_idx(s_r.ldi),
		.rd_data(nvm_word),
		.prog_ok(nvm_prog_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] idx_of(input logic [7:0] a);
		case (a)
			OFS_ALERT_MASK: idx_of = 4'h0;
			OFS_CABLE_SUPPLY: idx_of = 4'h1;
			OFS_CABLE_ILIM: idx_of = 4'h2;
			OFS_CABLE_MON: idx_of = 4'h3;
			OFS_BUS_LIMIT: idx_of = 4'h4;
			OFS_SW_RESET: idx_of = 4'h5;
			OFS_DRAIN_TIME: idx_of = 4'h6;
			OFS_BUS_MON: idx_of = 4'h7;
			default: idx_of = IDX_NONE;
		endcase
	endfunction

	// the store-only word has no address and reads nowhere
	function automatic logic [7:0] rd_val(input logic [7:0] a, input nvl_top_st_t s,
		input logic [7:0] lim);
		logic [3:0] i;
		i = idx_of(a);
		if (i == IDX_NONE) begin
			rd_val = 8'h00;
		end else if (i == IDX_LIMIT) begin
			rd_val = lim;
		end else begin
			rd_val = s.regs[i];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		wr_en = 1'b0;
		wi = idx_of(s_r.ptr);
		rise = !s_r.scl_q && scl_s;
		fall = s_r.scl_q && !scl_s;
		start = s_r.scl_q && scl_s && s_r.sda_q && !sda_s;
		stop = s_r.scl_q && scl_s && !s_r.sda_q && sda_s;
		// unattached, the limit register shows its reset value, not the loaded one
		limit_view = port_attached ? s_r.regs[IDX_LIMIT] : FACTORY[IDX_LIMIT];
		s_nxt.scl_q = scl_s;
		s_nxt.sda_q = sda_s;

		case (s_r.ld)
			LD_HOLD: begin
				if (!rst_pin_s) begin
					s_nxt.ld = LD_LOAD;
					s_nxt.ldi = IDX_FIRST;
				end
			end
			LD_LOAD: begin
				s_nxt.regs[s_r.ldi] = nvm_word;
				s_nxt.ldi = s_r.ldi + 4'h1;
				if (s_r.ldi == IDX_LAST) begin
					s_nxt.ld = LD_READY;
				end
			end
			LD_READY: begin
			end
			default: begin
				s_nxt.ld = LD_HOLD;
			end
		endcase
		if (rst_pin_s) begin
			s_nxt.ld = LD_HOLD;
		end

		if (stop) begin
			s_nxt.st = I_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else if (start) begin
			s_nxt.st = I_ADDR;
			s_nxt.bitc = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else begin
			case (s_r.st)
				I_IDLE: begin
					s_nxt.sda_oe = 1'b0;
				end
				I_ADDR: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda_s};
						s_nxt.bitc = s_r.bitc + 4'h1;
					end else if (fall && s_r.bitc == BITS_BYTE) begin
						if (s_r.sh[7:1] == I2C_ADDR && s_r.ld == LD_READY) begin
							s_nxt.sda_oe = 1'b1;
							s_nxt.rw = s_r.sh[0];
							s_nxt.st = I_AACK;
						end else begin
							s_nxt.st = I_IDLE;
						end
					end
				end
				I_AACK: begin
					if (fall) begin
						s_nxt.bitc = 4'h0;
						if (s_r.rw) begin
							s_nxt.sh = rd_val(s_r.ptr, s_r, limit_view);
							s_nxt.sda_oe = ~s_nxt.sh[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = I_RDATA;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.first = 1'b1;
							s_nxt.st = I_WDATA;
						end
					end
				end
				I_WDATA: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda_s};
						s_nxt.bitc = s_r.bitc + 4'h1;
					end else if (fall && s_r.bitc == BITS_BYTE) begin
						s_nxt.sda_oe = 1'b1;
						s_nxt.st = I_DACK;
						if (s_r.first) begin
							s_nxt.ptr = s_r.sh;
							s_nxt.first = 1'b0;
						end else begin
							s_nxt.ptr = s_r.ptr + 8'h01;
							if (wi <= IDX_LAST) begin
								wr_en = 1'b1;
								// only bus-writable fields change; others keep their value
								s_nxt.regs[wi] = (s_r.regs[wi] & ~WR_MASK[wi]) |
									(s_r.sh & WR_MASK[wi]);
							end
						end
					end
				end
				I_DACK: begin
					if (fall) begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.bitc = 4'h0;
						s_nxt.st = I_WDATA;
					end
				end
				I_RDATA: begin
					if (rise) begin
						s_nxt.bitc = s_r.bitc + 4'h1;
					end else if (fall) begin
						if (s_r.bitc == BITS_BYTE) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = I_RACK;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
						end
					end
				end
				I_RACK: begin
					if (rise) begin
						s_nxt.nack = sda_s;
					end else if (fall) begin
						if (s_r.nack) begin
							s_nxt.st = I_IDLE;
						end else begin
							s_nxt.sh = rd_val(s_r.ptr, s_r, limit_view);
							s_nxt.sda_oe = ~s_nxt.sh[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.bitc = 4'h0;
							s_nxt.st = I_RDATA;
						end
					end
				end
				default: begin
					s_nxt.st = I_IDLE;
					s_nxt.sda_oe = 1'b0;
				end
			endcase
		end
		// nothing answers while the registers are being filled
		if (s_r.ld != LD_READY) begin
			s_nxt.st = I_IDLE;
			s_nxt.sda_oe = 1'b0;
		end

		s_nxt.sda_o = 1'b0;
		s_nxt.ready = (s_r.ld == LD_READY);
		// the software request resets the port logic, never the registers here
		s_nxt.typec_rst = rst_pin_s | s_r.regs[IDX_SW_RESET][B_SW_RST];
		s_nxt.prog_refused = prog_we && !nvm_prog_ok;
		s_nxt.amask = s_r.regs[0][F_AMASK +: 3];
		s_nxt.sup_on = s_r.regs[1][B_SUP_ON];
		s_nxt.drain_on = s_r.regs[1][B_DRAIN_ON];
		s_nxt.ilim = s_r.regs[2][F_ILIM +: 4];
		s_nxt.mon_en = s_r.regs[3][B_MON_EN];
		s_nxt.low_trip = s_r.regs[3][B_LOW_TRIP];
		s_nxt.low_shift = limit_view[F_LOW_SHIFT +: 4];
		s_nxt.dtime = s_r.regs[6][F_DTIME +: 4];
		s_nxt.win_off = s_r.regs[7][B_WIN_OFF];
		s_nxt.hi_off = s_r.regs[7][B_HI_OFF];
		s_nxt.safe0 = s_r.regs[7][B_SAFE0 +: 2];
		s_nxt.lo_off = s_r.regs[7][B_LO_OFF];
		s_nxt.stby_off = s_r.regs[IDX_NVM_ONLY][B_STBY_OFF];
		s_nxt.bdrain_off = s_r.regs[IDX_NVM_ONLY][B_BDRAIN_OFF];

		if (srst) begin
			// power-on release: start loading at once
			s_nxt = '0;
			s_nxt.ld = LD_LOAD;
			s_nxt.regs = FACTORY;
			s_nxt.st = I_IDLE;
			s_nxt.scl_q = 1'b1;
			s_nxt.sda_q = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign sda_o = s_r.sda_o;
	assign sda_oe = s_r.sda_oe;
	assign prog_refused = s_r.prog_refused;
	assign cfg_ready = s_r.ready;
	assign typec_reset = s_r.typec_rst;
	assign alert_mask = s_r.amask;
	assign cable_supply_on = s_r.sup_on;
	assign cable_supply_drain_on = s_r.drain_on;
	assign cable_supply_ilim = s_r.ilim;
	assign cable_supply_mon_on = s_r.mon_en;
	assign cable_supply_low_trip_select = s_r.low_trip;
	assign bus_low_limit_shift = s_r.low_shift;
	assign bus_drain_time_coefficient = s_r.dtime;
	assign bus_window_check_off = s_r.win_off;
	assign supply_high_trip_off = s_r.hi_off;
	assign bus_safe_zero_select = s_r.safe0;
	assign supply_low_trip_off = s_r.lo_off;
	assign standby_off = s_r.stby_off;
	assign bus_drain_path_off = s_r.bdrain_off;

	////////////////////////////////////////////////////////////////////////////////
	property p_quiet_loading;
		@(posedge core_clk) disable iff (srst)
		!s_r.ready |-> !s_r.sda_oe;
	endproperty
	a_quiet_loading: assert property (p_quiet_loading)
		else $error("target drove the data line before loading finished");

	property p_load_copy;
		@(posedge core_clk) disable iff (srst)
		s_r.ld == LD_LOAD && !rst_pin_s |=> s_r.regs[$past(s_r.ldi)] == $past(nvm_word);
	endproperty
	a_load_copy: assert property (p_load_copy)
		else $error("register not filled from the store");

	property p_ready_after_load;
		@(posedge core_clk) disable iff (srst)
		$rose(s_r.ready) |-> $past(s_r.ldi, 2) == IDX_LAST;
	endproperty
	a_ready_after_load: assert property (p_ready_after_load)
		else $error("ready raised before the last word loaded");

	property p_pin_hold;
		@(posedge core_clk) disable iff (srst)
		rst_pin_s |=> s_r.ld == LD_HOLD ##1 !s_r.ready;
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("reset pin did not stop the loader");

	property p_pin_release;
		@(posedge core_clk) disable iff (srst)
		s_r.ld == LD_HOLD && !rst_pin_s |=> s_r.ld == LD_LOAD && s_r.ldi == IDX_FIRST;
	endproperty
	a_pin_release: assert property (p_pin_release)
		else $error("loading did not restart on pin release");

	property p_sw_reset;
		@(posedge core_clk) disable iff (srst)
		s_r.regs[IDX_SW_RESET][B_SW_RST] && s_r.ld == LD_READY && !rst_pin_s && !wr_en
		|=> s_r.typec_rst && $stable(s_r.regs);
	endproperty
	a_sw_reset: assert property (p_sw_reset)
		else $error("software reset lost or disturbed registers");

	property p_nvm_only;
		@(posedge core_clk) disable iff (srst)
		s_r.ld == LD_READY && !rst_pin_s |=> $stable(s_r.regs[IDX_NVM_ONLY]);
	endproperty
	a_nvm_only: assert property (p_nvm_only)
		else $error("store-only word changed during operation");

	property p_keep_value;
		@(posedge core_clk) disable iff (srst)
		s_r.ld == LD_READY && !rst_pin_s && !wr_en |=> $stable(s_r.regs);
	endproperty
	a_keep_value: assert property (p_keep_value)
		else $error("register changed without a write or reset");

	property p_unattached;
		@(posedge core_clk) disable iff (srst)
		!port_attached |=> s_r.low_shift == FACTORY[IDX_LIMIT][F_LOW_SHIFT +: 4];
	endproperty
	a_unattached: assert property (p_unattached)
		else $error("limit shift not at reset value while unattached");
endmodule // nvl_loader

// >>> nvl_loader_tb.sv
// self-checking testbench of the start-up configuration loader
`timescale 1ns/1ps
module nvl_loader_tb;
	import nvl_pkg::*;
	logic core_clk, srst, reset_pin, port_attached, prog_we, scl, sda_low, sda_line;
	logic [31:0] prog_key;
	logic [3:0] prog_idx, cable_supply_ilim, bus_low_limit_shift, bus_drain_time_coefficient;
	logic [7:0] prog_data;
	logic sda_o, sda_oe, prog_refused, cfg_ready, typec_reset, cable_supply_on;
	logic cable_supply_drain_on, cable_supply_mon_on, cable_supply_low_trip_select;
	logic bus_window_check_off, supply_high_trip_off, supply_low_trip_off;
	logic standby_off, bus_drain_path_off;
	logic [2:0] alert_mask;
	logic [1:0] bus_safe_zero_select;
	int n_mismatch = 0;
	int num_checks = 0;
	// open-drain data line with pull-up
	assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
	nvl_loader nvl_loader_inst (.core_clk, .srst, .scl_i(scl), .sda_i(sda_line), .sda_o,
		.sda_oe, .reset_pin, .port_attached, .prog_key, .prog_we, .prog_idx, .prog_data,
		.prog_refused, .cfg_ready, .typec_reset, .alert_mask, .cable_supply_on,
		.cable_supply_drain_on, .cable_supply_ilim, .cable_supply_mon_on,
		.cable_supply_low_trip_select, .bus_low_limit_shift, .bus_drain_time_coefficient,
		.bus_window_check_off, .supply_high_trip_off, .bus_safe_zero_select,
		.supply_low_trip_off, .standby_off, .bus_drain_path_off);
	nvl_i2c_host nvl_i2c_host_inst (.core_clk, .sda_in(sda_line), .scl, .sda_low);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// bounded wait; outputs trail the registers by one edge, so settle two more
	task automatic wait_ready();
		int n;
		n = 0;
		while (cfg_ready !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		tick(2);
		chk({7'h00, cfg_ready}, 8'h01);
	endtask
	task automatic pin_reset();
		reset_pin = 1'b1;
		tick(8);
		chk({6'h00, cfg_ready, typec_reset}, 8'h01);
		reset_pin = 1'b0;
		wait_ready();
	endtask
	task automatic prog(input logic [31:0] k, input logic [3:0] i, input logic [7:0] d,
		output logic r);
		prog_key = k;
		prog_idx = i;
		prog_data = d;
		prog_we = 1'b1;
		tick(1);
		prog_we = 1'b0;
		r = prog_refused;
		tick(1);
		r = r | prog_refused;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_boot();
		logic [7:0] ofs [8] = '{8'h0C, 8'h18, 8'h1E, 8'h20, 8'h22, 8'h23, 8'h25, 8'h2E};
		logic [7:0] dflt [8] = '{8'h07, 8'h01, 8'h00, 8'h01, 8'h05, 8'h00, 8'h6F, 8'h01};
		logic [7:0] d;
		logic ok;
		wait_ready();
		chk({7'h00, standby_off}, 8'h01);
		chk({6'h00, cable_supply_drain_on, cable_supply_on}, 8'h01);
		chk({6'h00, cable_supply_mon_on, cable_supply_low_trip_select}, 8'h02);
		chk({7'h00, typec_reset}, 8'h00);
		chk({4'h0, bus_drain_time_coefficient}, 8'h06);
		chk({2'h0, bus_window_check_off, supply_high_trip_off, 1'b0, bus_safe_zero_select,
			supply_low_trip_off}, 8'h01);
		chk({5'h00, alert_mask}, 8'h07);
		chk({3'h0, cable_supply_ilim, bus_drain_path_off}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			nvl_i2c_host_inst.read_reg(ofs[i], d, ok);
			chk({7'h00, ok}, 8'h01);
			chk(d, dflt[i]);
		end
		$display("test boot done");
	endtask
	task automatic t_gate();
		logic [7:0] d;
		logic ok;
		reset_pin = 1'b1;
		tick(8);
		nvl_i2c_host_inst.write_reg(8'h18, 8'h02, ok);
		chk({7'h00, ok}, 8'h00);
		reset_pin = 1'b0;
		wait_ready();
		nvl_i2c_host_inst.read_reg(8'h18, d, ok);
		chk(d, 8'h01);
		$display("test gate done");
	endtask
	task automatic t_soft();
		logic [7:0] d;
		logic ok;
		port_attached = 1'b1;
		tick(3);
		chk({4'h0, bus_low_limit_shift}, 8'h05);
		port_attached = 1'b0;
		nvl_i2c_host_inst.write_reg(8'h22, 8'h0A, ok);
		nvl_i2c_host_inst.write_reg(8'h18, 8'h02, ok);
		nvl_i2c_host_inst.write_reg(8'h1E, 8'hFF, ok);
		chk({4'h0, cable_supply_ilim}, 8'h0F);
		chk({6'h00, cable_supply_drain_on, cable_supply_on}, 8'h02);
		chk({4'h0, bus_low_limit_shift}, 8'h05);
		port_attached = 1'b1;
		tick(3);
		chk({4'h0, bus_low_limit_shift}, 8'h0A);
		nvl_i2c_host_inst.write_reg(8'h23, 8'hFF, ok);
		nvl_i2c_host_inst.read_reg(8'h23, d, ok);
		chk(d, 8'h01);
		chk({6'h00, typec_reset, cable_supply_drain_on}, 8'h03);
		nvl_i2c_host_inst.write_reg(8'h23, 8'h00, ok);
		chk({7'h00, typec_reset}, 8'h00);
		pin_reset();
		chk({6'h00, cable_supply_drain_on, cable_supply_on}, 8'h01);
		chk({4'h0, bus_low_limit_shift}, 8'h05);
		chk({4'h0, cable_supply_ilim}, 8'h00);
		$display("test soft done");
	endtask
	task automatic t_prog();
		logic r;
		prog(~PASSWORD, 4'h1, 8'h02, r);
		chk({7'h00, r}, 8'h01);
		prog(PASSWORD, 4'h1, 8'h02, r);
		chk({7'h00, r}, 8'h00);
		prog(PASSWORD, 4'h3, 8'h02, r);
		prog(PASSWORD, 4'h8, 8'h00, r);
		chk({5'h00, standby_off, cable_supply_drain_on, cable_supply_on}, 8'h05);
		pin_reset();
		chk({5'h00, standby_off, cable_supply_drain_on, cable_supply_on}, 8'h02);
		chk({7'h00, cable_supply_low_trip_select}, 8'h00);
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		wait_ready();
		chk({5'h00, standby_off, cable_supply_drain_on, cable_supply_on}, 8'h05);
		$display("test prog done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge core_clk);
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		print_verdict();
	end
	initial begin
		srst = 1'b1;
		reset_pin = 1'b0;
		port_attached = 1'b0;
		prog_we = 1'b0;
		prog_key = 32'h0000_0000;
		prog_idx = 4'h0;
		prog_data = 8'h00;
		tick(16);
		srst = 1'b0;
		t_boot();
		t_gate();
		t_soft();
		t_prog();
		print_verdict();
	end
endmodule // nvl_loader_tb

// >>> nvl_nvm.sv
// embedded default store with password-gated reprogramming
`timescale 1ns/1ps
module nvl_nvm (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [31:0] prog_key,
	input wire logic prog_we,
	input wire logic [3:0] prog_idx,
	input wire logic [7:0] prog_data,
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_data,
	output logic prog_ok
);
	import nvl_pkg::*;
	typedef struct packed {
		logic [NWORDS-1:0][7:0] mem;
	} nvl_nvm_st_t;
	nvl_nvm_st_t s_r, s_nxt;
	always_comb begin
		s_nxt = s_r;
		prog_ok = prog_we && (prog_key == PASSWORD) && (prog_idx <= IDX_LAST);
		if (prog_ok) begin
			// software-only fields carry a zero mask and cannot be reprogrammed
			s_nxt.mem[prog_idx] = (s_r.mem[prog_idx] & ~NVM_PMASK[prog_idx]) |
				(prog_data & NVM_PMASK[prog_idx]);
		end
		if (srst) begin
			s_nxt.mem = FACTORY;
		end
	end
	always_ff @(posedge core_clk) begin
		s_r <= s_nxt;
	end
	assign rd_data = (rd_idx <= IDX_LAST) ? s_r.mem[rd_idx] : 8'h00;

	property p_locked;
		@(posedge core_clk) disable iff (srst)
		prog_we && (prog_key != PASSWORD) |=> $stable(s_r.mem);
	endproperty
	a_locked: assert property (p_locked)
		else $error("store changed without password");
endmodule // nvl_nvm

// >>> nvl_pkg.sv
// constants, types and register map of the start-up configuration loader
// Functional notes
// - power-on and pin resets copy stored defaults into registers
// - reprogrammed store gives later loaded defaults; here only pin-reset loads, as power-on reset restores FACTORY
// - store rewrite needs the customer password
// - software value holds until rewrite or reset
// - three classes; store-only fields not bus-writable
// - standby mode off by default, no register
// - cable supply drain defaults off at 18h
// - cable supply defaults on at 18h
// - low trip select defaults 0 (4.65 V)
// - software reset request defaults 0 at 23h
// - host waits load time before first access
// - power-on release starts the loading phase
// - reset pin release starts the loading phase
// - software reset keeps written register values
// - attach-dependent register shows reset value unattached
package nvl_pkg;
	localparam logic [7:0] OFS_ALERT_MASK = 8'h0C;
	localparam logic [7:0] OFS_CABLE_SUPPLY = 8'h18;
	localparam logic [7:0] OFS_CABLE_ILIM = 8'h1E;
	localparam logic [7:0] OFS_CABLE_MON = 8'h20;
	localparam logic [7:0] OFS_BUS_LIMIT = 8'h22;
	localparam logic [7:0] OFS_SW_RESET = 8'h23;
	localparam logic [7:0] OFS_DRAIN_TIME = 8'h25;
	localparam logic [7:0] OFS_BUS_MON = 8'h2E;
	localparam int NWORDS = 9;
	localparam logic [3:0] IDX_FIRST = 4'h0;
	localparam logic [3:0] IDX_LIMIT = 4'h4;
	localparam logic [3:0] IDX_SW_RESET = 4'h5;
	localparam logic [3:0] IDX_LAST = 4'h8;
	localparam logic [3:0] IDX_NVM_ONLY = 4'h8;
	localparam logic [3:0] IDX_NONE = 4'hF;
	// word order: 0Ch 18h 1Eh 20h 22h 23h 25h 2Eh, then the store-only word
	localparam logic [NWORDS-1:0][7:0] FACTORY =
		{8'h01, 8'h01, 8'h6F, 8'h00, 8'h05, 8'h01, 8'h00, 8'h01, 8'h07};
	localparam logic [NWORDS-1:0][7:0] NVM_PMASK =
		{8'h03, 8'h57, 8'hF0, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'h03, 8'h07};
	localparam logic [NWORDS-1:0][7:0] WR_MASK =
		{8'h00, 8'h57, 8'hF0, 8'h01, 8'hFF, 8'h03, 8'h0F, 8'h03, 8'h07};
	localparam int B_SUP_ON = 0;
	localparam int B_DRAIN_ON = 1;
	localparam int B_MON_EN = 0;
	localparam int B_LOW_TRIP = 1;
	localparam int B_SW_RST = 0;
	localparam int B_LO_OFF = 0;
	localparam int B_SAFE0 = 1;
	localparam int B_WIN_OFF = 4;
	localparam int B_HI_OFF = 6;
	localparam int B_STBY_OFF = 0;
	localparam int B_BDRAIN_OFF = 1;
	localparam int F_LOW_SHIFT = 0;
	localparam int F_DTIME = 4;
	localparam int F_ILIM = 0;
	localparam int F_AMASK = 0;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [2:0] SYNC_IDLE = 3'b011;
	// target address and password values are arbitrary
	localparam logic [6:0] I2C_ADDR = 7'h28;
	localparam logic [31:0] PASSWORD = 32'h5A5A_0F0F;
	typedef enum logic [2:0] {
		LD_HOLD = 3'b001,
		LD_LOAD = 3'b010,
		LD_READY = 3'b100
	} nvl_ld_t;
	typedef enum logic [6:0] {
		I_IDLE = 7'h01,
		I_ADDR = 7'h02,
		I_AACK = 7'h04,
		I_WDATA = 7'h08,
		I_DACK = 7'h10,
		I_RDATA = 7'h20,
		I_RACK = 7'h40
	} nvl_i2c_t;
endpackage

// >>> nvl_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module nvl_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_q
);
	import nvl_pkg::*;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} nvl_sync_st_t;
	nvl_sync_st_t s_r, s_nxt;
	logic [W-1:0] q_nxt;
	for (genvar i = 0; i < W; i++) begin : g_bit
		// a change counts only once stages two and three agree
		assign q_nxt[i] = (s_r.s2[i] == s_r.s3[i]) ? s_r.s3[i] : s_r.q[i];
	end
	always_comb begin
		s_nxt.s1 = pin_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.q = q_nxt;
		if (srst) begin
			s_nxt = {4{RST_VAL}};
		end
	end
	always_ff @(posedge core_clk) begin
		s_r <= s_nxt;
	end
	assign pin_q = s_r.q;
endmodule // nvl_sync
